//--- core/dacs_defs.svh
// Constants for the dual-channel converter serial link
`ifndef DACS_DEFS_SVH
`define DACS_DEFS_SVH

// ----------------------------------------
// Control word layout
// ----------------------------------------
`define DACS_CW_W 8
`define DACS_CHAN_LSB 3
`define DACS_CHAN_MID 4
`define DACS_CHAN_MSB 5
`define DACS_RES_W 8

// ----------------------------------------
// Frame timing in serial clock edges
// ----------------------------------------
`define DACS_CONV_CLKS 16
`define DACS_DIN_LAST 4'h7
`define DACS_TRACK_CLKS 4'h3
`define DACS_MSB_POS 4'h4
`define DACS_LSB_POS 4'hb
`define DACS_LAST_RISE 4'hf

// ----------------------------------------
// Clock rates
// ----------------------------------------
`define DACS_CLK_KHZ 50000
`define DACS_SCLK_MAX_KHZ 3200
`define DACS_SCLK_HALF ((`DACS_CLK_KHZ + 2 * `DACS_SCLK_MAX_KHZ - 1) / (2 * `DACS_SCLK_MAX_KHZ))

`endif

//--- core/dacs_pkg.sv
// Shared types of the dual-channel converter serial link
package dacs_pkg;
	typedef enum logic {DACS_CHAN_A, DACS_CHAN_B} dacs_chan_t;
	typedef enum logic {HS_IDLE, HS_RUN} dacs_host_state_t;
endpackage : dacs_pkg

//--- core/dacs_if.sv
// Four-wire serial link between converter and host
`timescale 1ns/1ps
interface dacs_if;
	logic cs_n;
	logic sclk;
	logic din;
	logic dout;
	logic dout_oe;
	modport device(input cs_n, input sclk, input din, output dout, output dout_oe);
	modport host(output cs_n, output sclk, output din, input dout);
endinterface : dacs_if

//--- core/dacs_device.sv
// Converter end of the serial link: frame logic clocked by the serial clock
//
// Overview of operation
// [R1] Host sends next conversion's channel each conversion
// [R2] Simultaneous select and clock fall: next rise first
// [R3] Full accuracy from first frame after power-up
// [R4] Channel register powers up on input A
// [R5] Channel field sits in control bits 5..3
// [R6] Control bits 7, 6, 2..0 are ignored
// [R7] Code 00 picks A, 01 picks B
// [R8] Straight binary result, half-step first transition
// [R9] Active with select low, down when high
// [R10] Power down from 16th fall to next 1st
// [R11] Sixteen clocks per conversion, back to back
// [R12] Serial clock at most 3.2 MHz
// [R13] Prefer full rate and fewer conversions
// [R14] Frames carry multiples of sixteen rising edges
// [R15] Control word sampled on first 8 rises
// [R16] Track 3 clocks, MSB out on 5th clock
// [R17] Output driven only while select is low
// [R18] Channel latched after 8th bit, used next track
// [R19] Non-result bit slots are driven low
`timescale 1ns/1ps
`include "dacs_defs.svh"

module dacs_device #(
	parameter int AIN_W = 10
) (
	dacs_if.device link,
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	input wire logic [AIN_W-1:0] i_analog_input_a,
	input wire logic [AIN_W-1:0] i_analog_input_b,
	output dacs_pkg::dacs_chan_t o_chan_sel,
	output logic o_powered_down
);
	import dacs_pkg::*;

	localparam logic [AIN_W:0] AIN_HALF = {{AIN_W{1'b0}}, 1'b1} << (AIN_W - 9);

	// ----------------------------------------
	// Reset and enable into the serial clock domain
	// ----------------------------------------
	logic rst_meta_r;
	logic rst_n_r;
	logic en_meta_r;
	logic en_r;

	// Serial clock must run during reset for the link side to see it
	always_ff @(posedge link.sclk) begin
		rst_meta_r <= i_rst_n;
		rst_n_r <= rst_meta_r;
	end

	always_ff @(posedge link.sclk) begin
		en_meta_r <= i_clk_en;
		en_r <= en_meta_r;
	end

	// ----------------------------------------
	// Analog inputs, one synchroniser per channel
	// ----------------------------------------
	logic [AIN_W-1:0] ain_meta_r [2];
	logic [AIN_W-1:0] ain_r [2];
	logic [AIN_W-1:0] ain_pins [2];

	assign ain_pins[0] = i_analog_input_a;
	assign ain_pins[1] = i_analog_input_b;

	// Inputs are treated as slow levels; a word changing at the sample
	// instant may be caught half old, half new
	for (genvar ch = 0; ch < 2; ch++) begin : g_ain
		always_ff @(posedge link.sclk) begin
			ain_meta_r[ch] <= ain_pins[ch];
			ain_r[ch] <= ain_meta_r[ch];
		end
	end

	function automatic logic [`DACS_RES_W-1:0] quantise(input logic [AIN_W-1:0] v);
		logic [AIN_W:0] s;
		s = {1'b0, v} + AIN_HALF;
		if (s[AIN_W]) begin
			quantise = {`DACS_RES_W{1'b1}};
		end else begin
			quantise = s[AIN_W-1 -: `DACS_RES_W];
		end
	endfunction : quantise

	// ----------------------------------------
	// Rising edge side: count, control word, channel
	// ----------------------------------------
	logic [3:0] cnt_r;
	logic [`DACS_CW_W-2:0] rx_r;
	logic [`DACS_CW_W-1:0] cw;
	dacs_chan_t pend_chan_r;
	dacs_chan_t conv_chan_r;

	assign cw = {rx_r, link.din};

	// Counter is held at zero while deselected, so the first rise with
	// select low is edge one even if both fell together
	always_ff @(posedge link.sclk) begin
		if (!rst_n_r) begin
			cnt_r <= 4'h0;
		end else if (en_r) begin
			if (link.cs_n) begin
				cnt_r <= 4'h0; // [R2]
			end else begin
				cnt_r <= cnt_r + 4'h1; // [R11] [R14]
			end
		end
	end

	always_ff @(posedge link.sclk) begin
		if (!rst_n_r) begin
			rx_r <= '0;
		end else if (en_r && !link.cs_n && cnt_r <= `DACS_DIN_LAST) begin
			rx_r <= cw[`DACS_CW_W-2:0]; // [R15]
		end
	end

	// Upper channel bit is ignored; middle bit set is illegal and the
	// previous choice is kept
	always_ff @(posedge link.sclk) begin
		if (!rst_n_r) begin
			pend_chan_r <= DACS_CHAN_A; // [R4]
		end else if (en_r && !link.cs_n && cnt_r == `DACS_DIN_LAST) begin
			if (!cw[`DACS_CHAN_MID]) begin // [R5] [R6] [R7]
				pend_chan_r <= cw[`DACS_CHAN_LSB] ? DACS_CHAN_B : DACS_CHAN_A; // [R18]
			end
		end
	end

	always_ff @(posedge link.sclk) begin
		if (!rst_n_r) begin
			conv_chan_r <= DACS_CHAN_A; // [R3] [R4]
		end else if (en_r && !link.cs_n && cnt_r == `DACS_LAST_RISE) begin
			conv_chan_r <= pend_chan_r; // [R1] [R18]
		end
	end

	// ----------------------------------------
	// Falling edge side: hold, shift out, power state
	// ----------------------------------------
	logic busy_r;
	logic [`DACS_RES_W-1:0] out_sh_r;
	logic dout_r;
	logic oe_r;
	logic pd_r;

	assign link.dout = dout_r;
	assign link.dout_oe = oe_r;

	always_ff @(negedge link.sclk) begin
		if (!rst_n_r) begin
			busy_r <= 1'b0;
		end else if (en_r) begin
			busy_r <= !link.cs_n && (cnt_r != 4'h0 || busy_r);
		end
	end

	// Sample taken when tracking ends, right after the third rise
	always_ff @(negedge link.sclk) begin
		if (!rst_n_r) begin
			out_sh_r <= '0;
		end else if (en_r && !link.cs_n) begin
			if (cnt_r == `DACS_TRACK_CLKS) begin
				out_sh_r <= quantise(ain_r[conv_chan_r]); // [R8] [R16]
			end else if (cnt_r >= `DACS_MSB_POS && cnt_r <= `DACS_LSB_POS) begin
				out_sh_r <= {out_sh_r[`DACS_RES_W-2:0], 1'b0};
			end
		end
	end

	// Bit for clock n+1 is launched on the fall after rise n
	always_ff @(negedge link.sclk) begin
		if (!rst_n_r) begin
			dout_r <= 1'b0;
		end else if (en_r) begin
			if (!link.cs_n && cnt_r >= `DACS_MSB_POS && cnt_r <= `DACS_LSB_POS) begin
				dout_r <= out_sh_r[`DACS_RES_W-1]; // [R16]
			end else begin
				dout_r <= 1'b0; // [R19]
			end
		end
	end

	// Enable follows select on the next falling edge, not instantly
	always_ff @(negedge link.sclk) begin
		if (!rst_n_r) begin
			oe_r <= 1'b0;
		end else if (en_r) begin
			oe_r <= !link.cs_n; // [R17]
		end
	end

	always_ff @(negedge link.sclk) begin
		if (!rst_n_r) begin
			pd_r <= 1'b1;
		end else if (en_r) begin
			pd_r <= link.cs_n || (busy_r && cnt_r == 4'h0); // [R9] [R10]
		end
	end

	// ----------------------------------------
	// Status back into the system clock domain
	// ----------------------------------------
	logic pd_meta_r;
	logic chan_meta_r;

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			pd_meta_r <= 1'b1;
			o_powered_down <= 1'b1;
		end else if (i_clk_en) begin
			pd_meta_r <= pd_r;
			o_powered_down <= pd_meta_r;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			chan_meta_r <= 1'b0;
			o_chan_sel <= DACS_CHAN_A;
		end else if (i_clk_en) begin
			chan_meta_r <= conv_chan_r;
			o_chan_sel <= chan_meta_r ? DACS_CHAN_B : DACS_CHAN_A;
		end
	end

endmodule : dacs_device

//--- core/dacs_host.sv
// Host end of the serial link: divider clock, framing, control and result words
`timescale 1ns/1ps
`include "dacs_defs.svh"

module dacs_host #(
	parameter int SCLK_HALF = `DACS_SCLK_HALF
) (
	dacs_if.host link,
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	input wire logic i_start,
	input wire logic [7:0] i_conv_count,
	input dacs_pkg::dacs_chan_t i_next_chan,
	output logic o_busy,
	output logic [`DACS_RES_W-1:0] o_result,
	output logic o_result_valid,
	output dacs_pkg::dacs_chan_t o_result_chan
);
	import dacs_pkg::*;

	localparam logic [7:0] HALF_LAST = 8'(SCLK_HALF - 1);

	// ----------------------------------------
	// Serial clock divider
	// ----------------------------------------
	logic [7:0] div_r;
	logic sclk_r;
	logic wrap;
	logic rise_evt;
	logic fall_evt;

	assign wrap = i_clk_en && div_r == HALF_LAST;
	assign rise_evt = wrap && !sclk_r;
	assign fall_evt = wrap && sclk_r;
	assign link.sclk = sclk_r;

	// Runs free so the converter side sees its reset; half period
	// rounded up keeps the rate at or below the ceiling
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			div_r <= 8'h00;
			sclk_r <= 1'b1;
		end else if (i_clk_en) begin
			div_r <= wrap ? 8'h00 : div_r + 8'h01;
			sclk_r <= wrap ? !sclk_r : sclk_r; // [R12] [R13]
		end
	end

	// ----------------------------------------
	// Returned data synchroniser
	// ----------------------------------------
	logic dout_meta_r;
	logic dout_s_r;

	always_ff @(posedge i_clock) begin
		dout_meta_r <= link.dout;
		dout_s_r <= dout_meta_r;
	end

	// ----------------------------------------
	// Request capture
	// ----------------------------------------
	dacs_host_state_t state_r;
	logic start_pend_r;
	logic [7:0] count_r;
	logic begin_frame;

	assign begin_frame = fall_evt && state_r == HS_IDLE && start_pend_r;

	// A new start in the cycle a frame begins is kept for the next frame
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			start_pend_r <= 1'b0;
			count_r <= 8'h00;
		end else if (i_clk_en) begin
			if (i_start && i_conv_count != 8'h00) begin
				start_pend_r <= 1'b1;
				count_r <= i_conv_count;
			end else if (begin_frame) begin
				start_pend_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Frame engine
	// ----------------------------------------
	logic [3:0] edge_r;
	logic [7:0] left_r;
	logic [`DACS_CW_W-1:0] tx_r;
	logic [`DACS_CONV_CLKS-1:0] rx_r;
	logic [`DACS_CONV_CLKS-1:0] rx_nxt;
	logic [`DACS_CW_W-1:0] word;
	dacs_chan_t sent_chan_r;
	dacs_chan_t cur_chan_r;
	logic conv_start;

	assign rx_nxt = {rx_r[`DACS_CONV_CLKS-2:0], dout_s_r};
	assign conv_start = begin_frame
		|| (fall_evt && state_r == HS_RUN && edge_r == 4'h0 && left_r != 8'h00);

	always_comb begin
		word = '0;
		word[`DACS_CHAN_LSB] = (i_next_chan == DACS_CHAN_B); // [R1] [R5] [R7]
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			state_r <= HS_IDLE;
			link.cs_n <= 1'b1;
			o_busy <= 1'b0;
		end else if (begin_frame) begin
			state_r <= HS_RUN;
			link.cs_n <= 1'b0; // [R2]
			o_busy <= 1'b1;
		end else if (fall_evt && state_r == HS_RUN && edge_r == 4'h0 && left_r == 8'h00) begin
			state_r <= HS_IDLE;
			link.cs_n <= 1'b1; // [R14]
			o_busy <= 1'b0;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			edge_r <= 4'h0;
			left_r <= 8'h00;
		end else if (begin_frame) begin
			edge_r <= 4'h0;
			left_r <= count_r;
		end else if (rise_evt && state_r == HS_RUN) begin
			edge_r <= edge_r + 4'h1;
			left_r <= (edge_r == `DACS_LAST_RISE) ? left_r - 8'h01 : left_r;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			tx_r <= '0;
			link.din <= 1'b0;
			sent_chan_r <= DACS_CHAN_A;
			cur_chan_r <= DACS_CHAN_A;
		end else if (conv_start) begin
			tx_r <= {word[`DACS_CW_W-2:0], 1'b0};
			link.din <= word[`DACS_CW_W-1];
			cur_chan_r <= sent_chan_r;
			sent_chan_r <= i_next_chan;
		end else if (fall_evt) begin
			tx_r <= {tx_r[`DACS_CW_W-2:0], 1'b0};
			link.din <= (state_r == HS_RUN) ? tx_r[`DACS_CW_W-1] : 1'b0;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			rx_r <= '0;
			o_result <= '0;
			o_result_valid <= 1'b0;
			o_result_chan <= DACS_CHAN_A;
		end else if (i_clk_en) begin
			o_result_valid <= 1'b0;
			if (rise_evt && state_r == HS_RUN) begin
				rx_r <= rx_nxt;
				if (edge_r == `DACS_LAST_RISE) begin
					o_result <= rx_nxt[11:4]; // [R16]
					o_result_valid <= 1'b1;
					o_result_chan <= cur_chan_r;
				end
			end
		end
	end

endmodule : dacs_host

//--- dv/dacs_chk.sv
// Link checker for the dual-channel converter serial link
`timescale 1ns/1ps
module dacs_chk (
	input wire logic i_rst_n,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic din,
	input wire logic dout,
	input wire logic dout_oe
);
	// ------------------------------
	// Rise count within a conversion
	// ------------------------------
	logic [3:0] rise_cnt_r;
	always_ff @(posedge sclk) begin
		if (cs_n) begin
			rise_cnt_r <= 4'h0;
		end else begin
			rise_cnt_r <= rise_cnt_r + 4'h1;
		end
	end
	default clocking cb @(posedge sclk); endclocking
	default disable iff (!i_rst_n);
	// ------------------------------
	// Link properties
	// ------------------------------
	chk_lead_zeros: assert property (!cs_n && dout_oe && rise_cnt_r < 4'h4 |-> !dout)
		else $error("dout high in a leading slot");
	chk_tail_zeros: assert property (!cs_n && dout_oe && rise_cnt_r > 4'hb |-> !dout)
		else $error("dout high in a trailing slot");
	chk_out_release: assert property (cs_n && $past(cs_n) |-> !dout_oe)
		else $error("dout driven while deselected");
	chk_out_drive: assert property (!cs_n && !$past(cs_n) |-> dout_oe)
		else $error("dout not driven while selected");
	chk_frame_len: assert property ($rose(cs_n) |-> rise_cnt_r == 4'h0)
		else $error("frame closed off a conversion boundary");
	chk_min_frame: assert property ($fell(cs_n) |-> (!cs_n) [*8] ##1 (!cs_n) [*8])
		else $error("conversion shorter than sixteen clocks");
	chk_mid_bit_clear: assert property (!cs_n && rise_cnt_r == 4'h3 |-> !din)
		else $error("channel middle bit set");
	chk_din_quiet: assert property (cs_n |-> !din)
		else $error("din active outside a frame");
endmodule : dacs_chk

//--- dv/dacs_test.sv
// Self-checking bench joining host and converter ends
`timescale 1ns/1ps
module dacs_test;
	import dacs_pkg::*;
	logic clk = 1'b0;
	logic rst_host_n = 1'b0;
	logic rst_dev_n = 1'b0;
	logic start = 1'b0;
	logic [7:0] conv_count = 8'h00;
	dacs_chan_t next_chan = DACS_CHAN_A;
	logic [9:0] ain_a = 10'h000;
	logic [9:0] ain_b = 10'h000;
	logic busy, result_valid, powered_down;
	logic [7:0] result;
	dacs_chan_t result_chan, chan_sel;
	dacs_chan_t exp_chan = DACS_CHAN_A;
	int fail_count = 0;
	int samples_checked = 0;
	dacs_if link ();
	dacs_host dacs_host_i (.link(link), .i_clock(clk), .i_rst_n(rst_host_n), .i_clk_en(1'b1),
		.i_start(start), .i_conv_count(conv_count), .i_next_chan(next_chan), .o_busy(busy),
		.o_result(result), .o_result_valid(result_valid), .o_result_chan(result_chan));
	dacs_device dacs_device_i (.link(link), .i_clock(clk), .i_rst_n(rst_dev_n), .i_clk_en(1'b1),
		.i_analog_input_a(ain_a), .i_analog_input_b(ain_b), .o_chan_sel(chan_sel),
		.o_powered_down(powered_down));
	dacs_chk dacs_chk_i (.i_rst_n(rst_dev_n), .cs_n(link.cs_n), .sclk(link.sclk),
		.din(link.din), .dout(link.dout), .dout_oe(link.dout_oe));
	initial begin
		forever #10 clk = ~clk;
	end
	// ------------------------------
	// Checking helpers
	// ------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic complete_run();
		$display("mismatches %0d, comparisons %0d", fail_count, samples_checked);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : complete_run
	// Half-step offset: code steps at odd multiples of half an LSB
	function automatic logic [7:0] code_of(input logic [9:0] v);
		logic [10:0] s;
		s = {1'b0, v} + 11'h002;
		return (s[10:2] > 9'h0ff) ? 8'hff : s[9:2];
	endfunction : code_of
	// ------------------------------
	// Frame of n conversions, all asking for req
	// ------------------------------
	task automatic run_frame(input int n, input dacs_chan_t req);
		int k;
		int pd_seen;
		pd_seen = 0;
		@(posedge clk);
		next_chan <= req;
		conv_count <= n[7:0];
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		for (int j = 0; j < n; j++) begin
			for (k = 0; k < 2000; k++) begin
				@(posedge clk);
				#1;
				if (j > 0 && powered_down === 1'b1) pd_seen++;
				if (j == 0 && k == 60) check(powered_down, 8'h00);
				if (j == 0 && k == 60) check(busy, 8'h01);
				if (j == 0 && k == 100) check(chan_sel, exp_chan);
				if (result_valid === 1'b1) break;
			end
			if (k == 2000) begin
				fail_count++;
				complete_run();
			end
			check(result_chan, exp_chan);
			check(result, code_of(exp_chan == DACS_CHAN_A ? ain_a : ain_b));
			// Valid is a one-cycle pulse per conversion
			@(posedge clk);
			#1;
			check(result_valid, 8'h00);
			exp_chan = req;
		end
		if (n > 1) check(pd_seen > 0, 8'h01);
		for (k = 0; k < 400 && busy !== 1'b0; k++) @(posedge clk);
		if (k == 400) begin
			fail_count++;
			complete_run();
		end
		repeat (40) @(posedge clk);
		#1;
		check(powered_down, 8'h01);
		check(link.dout_oe, 8'h00);
		check(busy, 8'h00);
	endtask : run_frame
	// ------------------------------
	// Main sequence
	// ------------------------------
	initial begin
		repeat (5) @(posedge clk);
		rst_host_n <= 1'b1;
		// Device side resets only once the link clock runs
		repeat (80) @(posedge clk);
		rst_dev_n <= 1'b1;
		ain_a <= 10'h002;
		ain_b <= 10'h3ff;
		repeat (70) @(posedge clk);
		run_frame(1, DACS_CHAN_B);
		run_frame(3, DACS_CHAN_A);
		@(posedge clk);
		ain_a <= 10'h001;
		ain_b <= 10'h000;
		run_frame(2, DACS_CHAN_B);
		@(posedge clk);
		ain_a <= 10'h155;
		run_frame(2, DACS_CHAN_A);
		complete_run();
	end
endmodule : dacs_test
